// >>> common/arb_map.svh
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH
// Device register indices on the shared register port
`define ARB_REG_RSTA 3'h0
`define ARB_REG_RDATA 3'h1
`define ARB_REG_BAUD 3'h2
`define ARB_REG_DIVL 3'h3
`define ARB_REG_DIVH 3'h4
`define ARB_REG_INTC 3'h5
// Receive status/control bits
`define ARB_RSTA_SERIAL_PORT_ENABLE 7
`define ARB_RSTA_RX9 6
`define ARB_RSTA_RECEIVE_ENABLE 4
`define ARB_RSTA_ADDRESS_DETECT_ENABLE 3
`define ARB_RSTA_FRAMING_ERROR_FLAG 2
`define ARB_RSTA_OVERRUN_ERROR_FLAG 1
`define ARB_RSTA_RECEIVED_NINTH_BIT 0
// Baud control bits
`define ARB_BAUD_WIDE_DIVISOR_SELECT 3
`define ARB_BAUD_HIGH_SPEED_SELECT 2
`define ARB_BAUD_SYNC 1
`define ARB_BAUD_IDLE 0
// Interrupt control bits
`define ARB_INTC_RXIE 1
`define ARB_INTC_PEND 0
// Baud period multipliers, FIFO depth and character bit counts
`define ARB_MULT_64 7'h40
`define ARB_MULT_16 7'h10
`define ARB_MULT_4 7'h04
`define ARB_FIFO_DEPTH 2'h2
`define ARB_BITS_8 4'h8
`define ARB_BITS_9 4'h9
// Controller AXI4-Lite offsets and response codes
`define ARB_AXI_CMD 4'h0
`define ARB_AXI_CFG 4'h4
`define ARB_AXI_STAT 4'h8
`define ARB_AXI_DATA 4'hC
`define ARB_RESP_OKAY 2'h0
`define ARB_RESP_SLVERR 2'h2
// Controller sequence entry points
`define ARB_SEQ_SETUP 4'h0
`define ARB_SEQ_READ 4'h8
`define ARB_SEQ_MATCH 4'hA
`define ARB_SEQ_END 4'hB
`define ARB_SEQ_OVR 4'hC
`endif

// >>> common/arb_pkg.sv
package arb_pkg;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } arb_rx_state_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_ISSUE = 4'h2,
    HS_ACT = 4'h4,
    HS_CAP = 4'h8
  } arb_host_state_t;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_POLL = 2'h2
  } arb_op_t;
endpackage

// >>> common/arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  logic [2:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic rx_irq;
  modport device (input reg_addr, input reg_wr, input reg_rd, input reg_wdata, output reg_rdata, output rx_irq);
  modport host (output reg_addr, output reg_wr, output reg_rd, output reg_wdata, input reg_rdata, input rx_irq);
endinterface
`default_nettype wire

// >>> core/arb_rx_device.sv
// Functional notes
// R01 - Each FIFO entry keeps its framing error
// R02 - Framing error read-only, reception continues
// R03 - Data read pops FIFO to next entry
// R04 - Port disable resets; receive disable keeps flag
// R05 - Framing error alone requests no interrupt
// R06 - Two entries; third character sets overrun
// R07 - Overrun keeps FIFO, blocks new characters
// R08 - Overrun cleared by receive or port disable
// R09 - Nine-bit mode shifts nine, stores ninth
// R10 - Software reads ninth bit before data
// R11 - Software reads framing flag before data
// R12 - Address detect needs nine-bit receive
// R13 - Address mode admits only ninth-bit characters
// R14 - Address mode entries read ninth bit one
// R15 - Software clears address detect after match
// R16 - Pending on transfer; interrupt needs enable
// R17 - Software configures in documented order
// R18 - Divisor eight bits, or sixteen when wide
// R19 - Multiplier from speed and width; sync ignores
// R20 - Divisor write restarts baud timer
// R21 - Software checks idle before clock change
// R22 - Baud equals clock over multiplier times divisor+1
`timescale 1ns/1ps
`default_nettype none
`include "arb_map.svh"
module arb_rx_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  arb_if.device bus,
  // Serial line from remote transmitter
  input wire logic rx_pin
);
  logic rx_meta_reg, rx_sync_reg;
  logic rx_prev_reg;
  logic serial_port_enable_reg, rx9_reg, receive_enable_reg, address_detect_enable_reg;
  logic wide_divisor_select_reg, high_speed_select_reg, sync_reg;
  logic rxie_reg, overrun_error_flag_reg;
  logic [7:0] divl_reg, divh_reg, rdata_reg;
  logic [15:0] brg_cnt_reg;
  logic [6:0] tick_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [1:0] count_reg;
  logic rd_ptr_reg;
  logic [9:0] fifo_reg [0:1];
  arb_pkg::arb_rx_state_t state_reg, state_next;

  wire wr_rsta = bus.reg_wr && bus.reg_addr == `ARB_REG_RSTA;
  wire wr_baud = bus.reg_wr && bus.reg_addr == `ARB_REG_BAUD;
  wire wr_divl = bus.reg_wr && bus.reg_addr == `ARB_REG_DIVL;
  wire wr_divh = bus.reg_wr && bus.reg_addr == `ARB_REG_DIVH;
  wire wr_intc = bus.reg_wr && bus.reg_addr == `ARB_REG_INTC;
  wire rd_data = bus.reg_rd && bus.reg_addr == `ARB_REG_RDATA;

  // Baud timer
  wire [15:0] divisor = wide_divisor_select_reg ? {divh_reg, divl_reg} : {8'h00, divl_reg}; // R18
  wire [6:0] mult = sync_reg ? `ARB_MULT_4 : // R19
                    (wide_divisor_select_reg && high_speed_select_reg) ? `ARB_MULT_4 :
                    (wide_divisor_select_reg || high_speed_select_reg) ? `ARB_MULT_16 : `ARB_MULT_64; // R22
  wire [6:0] half = {1'b0, mult[6:1]};
  // Compare with >= so a smaller divisor after a mode switch never strands the timer
  wire tick = brg_cnt_reg >= divisor; // R22
  wire rx_on = serial_port_enable_reg && receive_enable_reg && !sync_reg;
  // Falling edge only: a stop bit sampled low must not restart reception
  wire start_edge = rx_prev_reg && !rx_sync_reg;

  // Receiver timing
  wire [3:0] nbits = rx9_reg ? `ARB_BITS_9 : `ARB_BITS_8; // R09
  wire bit_end = tick && tick_cnt_reg == mult - 7'h01;
  wire half_end = tick && tick_cnt_reg == half - 7'h01;
  wire last_bit = bit_cnt_reg == nbits - 4'h1;
  wire done = state_reg == arb_pkg::RX_STOP && bit_end;
  wire [7:0] char_data = rx9_reg ? shift_reg[7:0] : shift_reg[8:1];
  wire char_ninth = rx9_reg & shift_reg[8]; // R09
  wire char_framing_error_flag = !rx_sync_reg; // R01
  wire addr_skip = address_detect_enable_reg && rx9_reg && !char_ninth; // R12 R13
  wire fifo_full = count_reg == `ARB_FIFO_DEPTH;
  wire push = done && !overrun_error_flag_reg && !addr_skip && !fifo_full; // R02 R07
  wire ovr_set = done && !overrun_error_flag_reg && !addr_skip && fifo_full; // R06
  wire pop = rd_data && count_reg != 2'h0; // R03
  wire wr_idx = rd_ptr_reg ^ count_reg[0];

  // Head of FIFO seen by software
  wire [9:0] head = count_reg != 2'h0 ? fifo_reg[rd_ptr_reg] : 10'h000;
  wire pending = count_reg != 2'h0; // R05 R16
  wire [7:0] rsta_view = {serial_port_enable_reg, rx9_reg, 1'b0, receive_enable_reg, address_detect_enable_reg, head[9], overrun_error_flag_reg, head[8]}; // R01 R11
  wire [7:0] baud_view = {4'h0, wide_divisor_select_reg, high_speed_select_reg, sync_reg, state_reg == arb_pkg::RX_IDLE}; // R21
  wire [7:0] rd_mux = bus.reg_addr == `ARB_REG_RSTA ? rsta_view :
                      bus.reg_addr == `ARB_REG_RDATA ? head[7:0] :
                      bus.reg_addr == `ARB_REG_BAUD ? baud_view :
                      bus.reg_addr == `ARB_REG_DIVL ? divl_reg :
                      bus.reg_addr == `ARB_REG_DIVH ? divh_reg :
                      bus.reg_addr == `ARB_REG_INTC ? {6'h00, rxie_reg, pending} : 8'h00;
  assign bus.reg_rdata = rdata_reg;
  assign bus.rx_irq = pending && rxie_reg; // R16

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      arb_pkg::RX_IDLE: if (rx_on && start_edge) state_next = arb_pkg::RX_START;
      arb_pkg::RX_START: if (half_end) state_next = rx_sync_reg ? arb_pkg::RX_IDLE : arb_pkg::RX_DATA;
      arb_pkg::RX_DATA: if (bit_end && last_bit) state_next = arb_pkg::RX_STOP;
      arb_pkg::RX_STOP: if (bit_end) state_next = arb_pkg::RX_IDLE;
      default: state_next = arb_pkg::RX_IDLE;
    endcase
    if (!rx_on) state_next = arb_pkg::RX_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Software-written controls and captured read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_port_enable_reg <= 1'b0;
      rx9_reg <= 1'b0;
      receive_enable_reg <= 1'b0;
      address_detect_enable_reg <= 1'b0;
      wide_divisor_select_reg <= 1'b0;
      high_speed_select_reg <= 1'b0;
      sync_reg <= 1'b0;
      rxie_reg <= 1'b0;
      divl_reg <= 8'h00;
      divh_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      if (wr_rsta) begin
        serial_port_enable_reg <= bus.reg_wdata[`ARB_RSTA_SERIAL_PORT_ENABLE];
        rx9_reg <= bus.reg_wdata[`ARB_RSTA_RX9];
        receive_enable_reg <= bus.reg_wdata[`ARB_RSTA_RECEIVE_ENABLE];
        address_detect_enable_reg <= bus.reg_wdata[`ARB_RSTA_ADDRESS_DETECT_ENABLE];
      end
      if (wr_baud) begin
        wide_divisor_select_reg <= bus.reg_wdata[`ARB_BAUD_WIDE_DIVISOR_SELECT];
        high_speed_select_reg <= bus.reg_wdata[`ARB_BAUD_HIGH_SPEED_SELECT];
        sync_reg <= bus.reg_wdata[`ARB_BAUD_SYNC];
      end
      if (wr_divl) divl_reg <= bus.reg_wdata;
      if (wr_divh) divh_reg <= bus.reg_wdata;
      if (wr_intc) rxie_reg <= bus.reg_wdata[`ARB_INTC_RXIE];
      if (bus.reg_rd) rdata_reg <= rd_mux;
    end
  end

  // Free-running baud timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) brg_cnt_reg <= 16'h0000;
    else if (wr_divl || wr_divh || tick) brg_cnt_reg <= 16'h0000; // R20
    else brg_cnt_reg <= brg_cnt_reg + 16'h0001;
  end

  // Receive sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= arb_pkg::RX_IDLE;
      tick_cnt_reg <= 7'h00;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      if (state_reg != state_next || bit_end) tick_cnt_reg <= 7'h00;
      else if (tick) tick_cnt_reg <= tick_cnt_reg + 7'h01;
      if (state_reg != arb_pkg::RX_DATA) bit_cnt_reg <= 4'h0;
      else if (bit_end) bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (state_reg == arb_pkg::RX_DATA && bit_end) shift_reg <= {rx_sync_reg, shift_reg[8:1]}; // R09
    end
  end

  // FIFO pointers and overrun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 2'h0;
      rd_ptr_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
    end else if (!serial_port_enable_reg) begin
      count_reg <= 2'h0; // R04
      rd_ptr_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0; // R08
    end else begin
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      if (pop) rd_ptr_reg <= !rd_ptr_reg; // R03
      if (!receive_enable_reg) overrun_error_flag_reg <= 1'b0; // R08
      else if (ovr_set) overrun_error_flag_reg <= 1'b1; // R06 R07
    end
  end

  // FIFO storage: framing flag, ninth bit, data
  genvar gi;
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) fifo_reg[gi] <= 10'h000;
      else if (push && wr_idx == 1'(gi)) fifo_reg[gi] <= {char_framing_error_flag, addr_skip ? 1'b1 : char_ninth, char_data}; // R01 R14
    end
  end
endmodule // arb_rx_device
`default_nettype wire

// >>> core/arb_rx_host.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "arb_map.svh"
module arb_rx_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device register port
  arb_if.host dev
);
  arb_pkg::arb_host_state_t state_reg;
  logic [19:0] cfg_reg;
  logic [3:0] seq_reg;
  logic address_detect_enable_on_reg, valid_reg, framing_error_flag_reg, overrun_error_flag_reg, ninth_reg, idle_reg;
  logic [7:0] data_reg;
  logic [2:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg, rd_reg, bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Op table: kind, device index, data, last
  wire rx9 = cfg_reg[18];
  wire [7:0] rs_base = (8'h01 << `ARB_RSTA_SERIAL_PORT_ENABLE) | ({7'h00, rx9} << `ARB_RSTA_RX9);
  wire [7:0] rs_addr = {7'h00, cfg_reg[19]} << `ARB_RSTA_ADDRESS_DETECT_ENABLE;
  wire [7:0] rs_cur = {7'h00, address_detect_enable_on_reg} << `ARB_RSTA_ADDRESS_DETECT_ENABLE;
  wire [7:0] rs_receive_enable = 8'h01 << `ARB_RSTA_RECEIVE_ENABLE;
  wire [7:0] baud_w = {4'h0, cfg_reg[17], cfg_reg[16], 2'h0};
  function automatic logic [13:0] op_of(input logic [3:0] s);
    unique case (s)
      4'h0: op_of = {arb_pkg::OP_POLL, `ARB_REG_BAUD, 8'h00, 1'b0}; // R21
      4'h1: op_of = {arb_pkg::OP_WRITE, `ARB_REG_DIVL, cfg_reg[7:0], 1'b0};
      4'h2: op_of = {arb_pkg::OP_WRITE, `ARB_REG_DIVH, cfg_reg[15:8], 1'b0};
      4'h3: op_of = {arb_pkg::OP_WRITE, `ARB_REG_BAUD, baud_w, 1'b0};
      4'h4: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, 8'h01 << `ARB_RSTA_SERIAL_PORT_ENABLE, 1'b0}; // R17
      4'h5: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base, 1'b0}; // R17
      4'h6: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_addr, 1'b0}; // R17
      4'h7: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_addr | rs_receive_enable, 1'b1}; // R17
      4'h8: op_of = {arb_pkg::OP_READ, `ARB_REG_RSTA, 8'h00, 1'b0}; // R10 R11
      4'h9: op_of = {arb_pkg::OP_READ, `ARB_REG_RDATA, 8'h00, 1'b1};
      4'hA: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_receive_enable, 1'b1}; // R15
      4'hB: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_addr | rs_receive_enable, 1'b1}; // R15
      4'hC: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_cur, 1'b0};
      4'hD: op_of = {arb_pkg::OP_WRITE, `ARB_REG_RSTA, rs_base | rs_cur | rs_receive_enable, 1'b1};
      default: op_of = {arb_pkg::OP_WRITE, `ARB_REG_INTC, 8'h00, 1'b1};
    endcase
  endfunction
  wire [13:0] op = op_of(seq_reg);
  wire [1:0] op_kind = op[13:12];
  wire op_last = op[0];

  // AXI decode
  wire busy = state_reg != arb_pkg::HS_IDLE;
  wire wtake = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  wire rtake = s_axi_arvalid && !rvalid_reg;
  wire w_cmd = wtake && s_axi_awaddr == `ARB_AXI_CMD;
  wire w_cfg = wtake && s_axi_awaddr == `ARB_AXI_CFG;
  wire w_ok = w_cmd || w_cfg;
  wire start = w_cmd && !busy && s_axi_wstrb[0] && s_axi_wdata[4:0] != 5'h00;
  wire [3:0] entry = s_axi_wdata[0] ? `ARB_SEQ_SETUP : s_axi_wdata[1] ? `ARB_SEQ_READ :
                     s_axi_wdata[2] ? `ARB_SEQ_MATCH : s_axi_wdata[3] ? `ARB_SEQ_END : `ARB_SEQ_OVR;
  wire [31:0] stat = {25'h0, dev.rx_irq, idle_reg, ninth_reg, overrun_error_flag_reg, framing_error_flag_reg, valid_reg, busy};
  wire r_ok = s_axi_araddr == `ARB_AXI_CMD || s_axi_araddr == `ARB_AXI_CFG ||
              s_axi_araddr == `ARB_AXI_STAT || s_axi_araddr == `ARB_AXI_DATA;
  wire [31:0] r_mux = s_axi_araddr == `ARB_AXI_CFG ? {12'h000, cfg_reg} :
                      s_axi_araddr == `ARB_AXI_STAT ? stat :
                      s_axi_araddr == `ARB_AXI_DATA ? {24'h000000, data_reg} : 32'h00000000;
  wire status_rd = rtake && s_axi_araddr == `ARB_AXI_STAT;
  assign s_axi_awready = wtake;
  assign s_axi_wready = wtake;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign dev.reg_addr = addr_reg;
  assign dev.reg_wdata = wdata_reg;
  assign dev.reg_wr = wr_reg;
  assign dev.reg_rd = rd_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `ARB_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `ARB_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      cfg_reg <= 20'h00000;
    end else begin
      if (wtake) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_ok ? `ARB_RESP_OKAY : `ARB_RESP_SLVERR;
      end else if (s_axi_bready) bvalid_reg <= 1'b0;
      if (rtake) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= r_ok ? `ARB_RESP_OKAY : `ARB_RESP_SLVERR;
        rdata_reg <= r_mux;
      end else if (s_axi_rready) rvalid_reg <= 1'b0;
      if (w_cfg && !busy) cfg_reg <= s_axi_wdata[19:0];
    end
  end

  // Sequencer over the device port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= arb_pkg::HS_IDLE;
      seq_reg <= 4'h0;
      {wr_reg, rd_reg, address_detect_enable_on_reg} <= 3'h0;
      addr_reg <= 3'h0;
      wdata_reg <= 8'h00;
      {valid_reg, framing_error_flag_reg, overrun_error_flag_reg, ninth_reg, idle_reg} <= 5'h00;
      data_reg <= 8'h00;
    end else begin
      if (status_rd) valid_reg <= 1'b0;
      unique case (state_reg)
        arb_pkg::HS_IDLE: if (start) begin
          seq_reg <= entry;
          state_reg <= arb_pkg::HS_ISSUE;
        end
        arb_pkg::HS_ISSUE: begin
          addr_reg <= op[11:9];
          wdata_reg <= op[8:1];
          wr_reg <= op_kind == arb_pkg::OP_WRITE;
          rd_reg <= op_kind != arb_pkg::OP_WRITE;
          state_reg <= arb_pkg::HS_ACT;
        end
        arb_pkg::HS_ACT: begin
          {wr_reg, rd_reg} <= 2'h0;
          state_reg <= arb_pkg::HS_CAP;
        end
        arb_pkg::HS_CAP: begin
          if (seq_reg == `ARB_SEQ_READ) begin
            framing_error_flag_reg <= dev.reg_rdata[`ARB_RSTA_FRAMING_ERROR_FLAG]; // R11
            overrun_error_flag_reg <= dev.reg_rdata[`ARB_RSTA_OVERRUN_ERROR_FLAG];
            ninth_reg <= dev.reg_rdata[`ARB_RSTA_RECEIVED_NINTH_BIT]; // R10
          end
          if (seq_reg == `ARB_SEQ_READ + 4'h1) begin
            data_reg <= dev.reg_rdata;
            valid_reg <= 1'b1;
          end
          if (op_kind == arb_pkg::OP_POLL) idle_reg <= dev.reg_rdata[`ARB_BAUD_IDLE];
          if (seq_reg == 4'h6 || seq_reg == `ARB_SEQ_END) address_detect_enable_on_reg <= cfg_reg[19];
          if (seq_reg == `ARB_SEQ_MATCH) address_detect_enable_on_reg <= 1'b0; // R15
          if (op_kind == arb_pkg::OP_POLL && !dev.reg_rdata[`ARB_BAUD_IDLE]) state_reg <= arb_pkg::HS_ISSUE; // R21
          else if (op_last) state_reg <= arb_pkg::HS_IDLE;
          else begin
            seq_reg <= seq_reg + 4'h1;
            state_reg <= arb_pkg::HS_ISSUE;
          end
        end
        default: state_reg <= arb_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // arb_rx_host
`default_nettype wire

// >>> tb/arb_rx_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "arb_map.svh"
module arb_rx_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_irq
);
  logic [7:0] rsta_reg;
  logic [3:1] baud_reg;
  logic rxie_reg;
  logic sta_seen_reg;
  wire logic wr_rsta = reg_wr && (reg_addr == `ARB_REG_RSTA);
  wire logic wr_baud = reg_wr && (reg_addr == `ARB_REG_BAUD);
  wire logic wr_intc = reg_wr && (reg_addr == `ARB_REG_INTC);
  wire logic rd_rsta = reg_rd && (reg_addr == `ARB_REG_RSTA);
  wire logic rd_baud = reg_rd && (reg_addr == `ARB_REG_BAUD);
  wire logic rd_data = reg_rd && (reg_addr == `ARB_REG_RDATA);

  // Shadows of what the host wrote, for read-back and ordering
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsta_reg <= 8'h00;
      baud_reg <= 3'h0;
      rxie_reg <= 1'b0;
      sta_seen_reg <= 1'b0;
    end else begin
      if (wr_rsta) rsta_reg <= reg_wdata;
      if (wr_baud) baud_reg <= reg_wdata[3:1];
      if (wr_intc) rxie_reg <= reg_wdata[`ARB_INTC_RXIE];
      if (rd_rsta) sta_seen_reg <= 1'b1;
      else if (rd_data) sta_seen_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_strobe_excl: assert property (!(reg_wr && reg_rd))
    else $error("Write and read strobes high together");
  chk_strobe_pulse: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*2])
    else $error("Register strobes closer than one operation");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("Read data changed without a read");
  chk_status_first: assert property (rd_data |-> sta_seen_reg)
    else $error("Data register read without a status read first");
  chk_setup_order: assert property (wr_rsta && reg_wdata[`ARB_RSTA_RECEIVE_ENABLE] |-> rsta_reg[`ARB_RSTA_SERIAL_PORT_ENABLE])
    else $error("Receive enabled before the port was enabled");
  chk_addr_nine: assert property (wr_rsta && reg_wdata[`ARB_RSTA_ADDRESS_DETECT_ENABLE] |-> reg_wdata[`ARB_RSTA_RX9])
    else $error("Address detect set without nine-bit receive");
  chk_rsta_back: assert property ($past(rd_rsta) |-> reg_rdata[7:6] == rsta_reg[7:6])
    else $error("Status control read-back differs from written value");
  chk_baud_back: assert property ($past(rd_baud) |-> reg_rdata[3:1] == baud_reg)
    else $error("Baud control read-back differs from written value");
  chk_irq_masked: assert property (rx_irq |-> rxie_reg)
    else $error("Receive interrupt raised while disabled");
endmodule // arb_rx_sva
`default_nettype wire

// >>> tb/async_uart_rx_error_addr_brg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "arb_map.svh"
module async_uart_rx_error_addr_brg_tb_top;
  logic clk, rst_n, rx_pin;
  logic [3:0] awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] st;
  logic [31:0] d;
  logic [1:0] r;
  // Mode table: {wide_divisor_select, high_speed_select} in [17:16], divisor in [15:0]
  logic [31:0] cfg_tab [5] = '{32'h0003_0003, 32'h0002_0000, 32'h0001_0101, 32'h0000_0000, 32'h0003_0100};

  arb_if bus_if ();
  arb_rx_device u_arb_rx_device (.clk(clk), .rst_n(rst_n), .bus(bus_if.device), .rx_pin(rx_pin));
  arb_rx_host u_arb_rx_host (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dev(bus_if.host));
  arb_rx_sva u_arb_rx_sva (.clk(clk), .rst_n(rst_n), .reg_addr(bus_if.reg_addr), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata), .rx_irq(bus_if.rx_irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready && !aw_ok) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wready && !w_ok) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Command, then poll status until the sequencer is idle
  task automatic cmd(input logic [31:0] c, output logic [31:0] s);
    logic [1:0] rs;
    axi_wr(`ARB_AXI_CMD, c);
    do axi_rd(`ARB_AXI_STAT, s, rs); while (s[0]);
  endtask

  task automatic setup(input logic [31:0] c);
    logic [31:0] s;
    axi_wr(`ARB_AXI_CFG, c);
    cmd(32'h0000_0001, s);
  endtask

  // Expected status {ninth, overrun, framing, valid}; irq stays low, idle high
  task automatic get_char(input logic [7:0] exp_d, input logic [3:0] exp_st);
    logic [31:0] s;
    logic [31:0] v;
    logic [1:0] rs;
    cmd(32'h0000_0002, s);
    chk({26'h0, s[6:1]}, {26'h0, 2'h1, exp_st});
    axi_rd(`ARB_AXI_DATA, v, rs);
    chk({24'h0, v[7:0]}, {24'h0, exp_d});
  endtask

  // Remote transmitter: start, data LSB first, stop, idle high
  task automatic send(input logic [8:0] v, input int nb, input logic stop, input int bt);
    rx_pin <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rx_pin <= v[i];
      repeat (bt) @(posedge clk);
    end
    rx_pin <= stop;
    repeat (bt) @(posedge clk);
    rx_pin <= 1'b1;
    repeat (3 * bt) @(posedge clk);
  endtask

  function automatic int bit_clocks(input logic [31:0] c);
    int m;
    m = c[17] ? (c[16] ? 4 : 16) : (c[16] ? 16 : 64);
    return m * ((c[17] ? int'(c[15:0]) : int'(c[7:0])) + 1);
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("ERROR at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    rx_pin = 1'b1;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Every multiplier, narrow divisor ignoring high byte, wide divisor
    for (int i = 0; i < 5; i++) begin
      setup(cfg_tab[i]);
      send(9'h0A5 ^ 9'(i), 8, 1'b1, bit_clocks(cfg_tab[i]));
      get_char(8'hA5 ^ 8'(i), 4'b0001);
    end
    setup(cfg_tab[0]);
    send(9'h033, 8, 1'b0, 16);
    send(9'h0C4, 8, 1'b1, 16);
    get_char(8'h33, 4'b0011);
    get_char(8'hC4, 4'b0001);
    send(9'h011, 8, 1'b1, 16);
    send(9'h022, 8, 1'b1, 16);
    send(9'h033, 8, 1'b1, 16);
    get_char(8'h11, 4'b0101);
    get_char(8'h22, 4'b0101);
    cmd(32'h0000_0010, st);
    send(9'h044, 8, 1'b1, 16);
    get_char(8'h44, 4'b0001);
    setup(32'h0007_0003);
    send(9'h15A, 9, 1'b1, 16);
    send(9'h0A5, 9, 1'b1, 16);
    get_char(8'h5A, 4'b1001);
    get_char(8'hA5, 4'b0001);
    // Address mode: non-address discarded, match opens, message end closes
    setup(32'h000F_0003);
    send(9'h066, 9, 1'b1, 16);
    send(9'h112, 9, 1'b1, 16);
    get_char(8'h12, 4'b1001);
    cmd(32'h0000_0004, st);
    send(9'h077, 9, 1'b1, 16);
    get_char(8'h77, 4'b0001);
    cmd(32'h0000_0008, st);
    send(9'h088, 9, 1'b1, 16);
    send(9'h134, 9, 1'b1, 16);
    get_char(8'h34, 4'b1001);
    axi_rd(4'h2, d, r);
    chk({30'h0, r}, {30'h0, `ARB_RESP_SLVERR});
    chk(d, 32'h0000_0000);
    close_out();
  end
endmodule // async_uart_rx_error_addr_brg_tb_top
`default_nettype wire
